// ===== test/lbm_logic_block_properties.sv
// Checker for the logic block bus answer and reset state.
// Assumes it is bound to lbm_logic_block and sees only its ports.
`timescale 1ns/1ps
module lbm_logic_block_chk
    import lbm_pkg::*;
#(
    parameter int NUM_IN = LBM_NUM_IN
) (
    // Clock and reset
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    // Block outputs
    input wire logic [LBM_NUM_MC-1:0] pool_out_o,
    input wire logic [LBM_NUM_IO-1:0] io_out_o,
    // Bus
    input wire logic                  avs_read_i,
    input wire logic                  avs_write_i,
    input wire logic [31:0]           avs_readdata_o,
    input wire logic                  avs_waitrequest_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ==========================================================================
    // Bus answer
    sequence s_req_start;
        ($rose(avs_read_i) || $rose(avs_write_i)) && avs_waitrequest_o;
    endsequence
    sequence s_answer;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence

    a_answer_next: assert property (s_req_start |=> s_answer)
        else $error("request not answered in the next cycle");
    a_wait_one_low: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_rdata_idle_zero: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0)
        else $error("read data not zero outside the answer");
    a_low_after_req: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
        else $error("answer without a request");
    a_no_idle_answer: assert property
        (!avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer while bus idle");

    // ==========================================================================
    // State after reset
    a_reset_pool_clear: assert property ($fell(rst_i) |-> pool_out_o == 16'h0)
        else $error("macrocells not cleared after reset");
    a_reset_io_clear: assert property ($fell(rst_i) |-> io_out_o == 12'h0)
        else $error("io outputs not cleared after reset");
    a_reset_bus_idle: assert property ($fell(rst_i) |-> avs_waitrequest_o)
        else $error("waitrequest low after reset");
endmodule

bind lbm_logic_block lbm_logic_block_chk #(.NUM_IN(NUM_IN)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .pool_out_o(pool_out_o), .io_out_o(io_out_o),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));

// ===== test/test_lbm_logic_block.sv
// Self-checking bench for the logic block: registers, macrocells, I/O routing.
// Assumes the design answers each bus request one cycle after taking it.
`timescale 1ns/1ps
module test_lbm_logic_block
    import lbm_pkg::*;
;
    logic        clk_i           = 1'b0;
    logic        rst_i           = 1'b1;
    logic [35:0] pool_in_i       = 36'h0;
    logic [15:0] pool_out_o;
    logic [3:0]  gclk_pin_i      = 4'h1;
    logic [11:0] io_in_i         = 12'h0;
    logic [11:0] io_out_o;
    logic [8:0]  avs_address_i   = 9'h0;
    logic        avs_read_i      = 1'b0;
    logic        avs_write_i     = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [31:0] q;
    int          n_fail          = 0;
    int          compares        = 0;

    lbm_logic_block dut_u (.clk_i(clk_i), .rst_i(rst_i), .pool_in_i(pool_in_i),
        .pool_out_o(pool_out_o), .gclk_pin_i(gclk_pin_i), .io_in_i(io_in_i),
        .io_out_o(io_out_o), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_byteenable_i(4'hf),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // ==========================================================================
    // Tasks
    task automatic stop_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic we, input logic [8:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= we;
        avs_read_i      <= !we;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 50) begin
            n_fail++;
        end
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    function automatic logic pick(input int i);
        return (i < 16) ? pool_out_o[i] : io_out_o[i-16];
    endfunction

    // Index below 16 is a macrocell, 16 and up an I/O cell
    task automatic wait_bit(input string nm, input int i, input logic v);
        int n;
        n = 0;
        while (pick(i) !== v && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        check(nm, {31'h0, pick(i)}, {31'h0, v});
    endtask

    // ==========================================================================
    // Tests
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("pool after reset", {16'h0, pool_out_o}, 32'h0);
        bus(1, LBM_ADDR_MC_BASE + 9'h4, 32'hffffffff);
        bus(0, LBM_ADDR_MC_BASE + 9'h4, 0);
        check("mc4 cfg readback", q, 32'h3fff);
        bus(1, LBM_ADDR_MC_BASE + 9'h4, 0);
        bus(1, 9'h1ff, 32'hffffffff);
        bus(0, 9'h1ff, 0);
        check("unmapped read", q, 32'h0);
        $display("test registers done");
        // Set, swapped reset, swapped set
        bus(1, LBM_ADDR_MC_BASE + 9'h0, 32'hc00);
        bus(1, LBM_ADDR_MC_BASE + 9'h1, 32'h1400);
        bus(1, LBM_ADDR_MC_BASE + 9'h2, 32'h1c00);
        bus(1, LBM_ADDR_CTRL, 32'h1);
        bus(0, LBM_ADDR_MC_STATE, 0);
        check("power-up state", q, 32'h3);
        bus(1, LBM_ADDR_MC_BASE + 9'h3, 32'hc00);
        bus(1, 9'h144, 32'h2);
        pool_in_i[1] <= 1'b1;
        wait_bit("block init mc3", 3, 1'b1);
        pool_in_i[1] <= 1'b0;
        $display("test initialization done");
        // Macrocell 3 sum term is term 19, fed by pool input 0
        bus(1, 9'h04c, 32'h1);
        bus(1, LBM_ADDR_MC_BASE + 9'h3, 32'h304);
        wait_bit("latch open low", 3, 1'b0);
        pool_in_i[0] <= 1'b1;
        wait_bit("latch open high", 3, 1'b1);
        bus(1, LBM_ADDR_MC_BASE + 9'h3, 32'h306);
        wait_bit("xor invert", 3, 1'b0);
        // Close the latch before the data moves; the clock lags two sync flops
        gclk_pin_i[0] <= 1'b0;
        repeat (4) @(posedge clk_i);
        pool_in_i[0]  <= 1'b0;
        repeat (8) @(posedge clk_i);
        check("latch closed hold", {31'h0, pool_out_o[3]}, 32'h0);
        bus(1, LBM_ADDR_MC_BASE + 9'h3, 32'h302);
        gclk_pin_i[0] <= 1'b1;
        wait_bit("register edge", 3, 1'b1);
        $display("test macrocell done");
        bus(1, LBM_ADDR_IO_BASE + 9'h0, 32'h3);
        bus(1, LBM_ADDR_IO_BASE + 9'h9, 32'h7);
        bus(1, LBM_ADDR_IO_BASE + 9'h1, 32'h18);
        bus(1, LBM_ADDR_IO_BASE + 9'h3, 32'h10);
        wait_bit("io0 from mc3", 16, 1'b1);
        wait_bit("io9 wraps to mc3", 25, 1'b1);
        wait_bit("io1 register bypass", 17, 1'b1);
        wait_bit("io3 fast inverted", 19, 1'b1);
        // Ground clock: no capture while pins toggle
        bus(1, LBM_ADDR_MC_BASE + 9'h3, 32'h3e2);
        pool_in_i[0]  <= 1'b1;
        gclk_pin_i[0] <= 1'b0;
        repeat (4) @(posedge clk_i);
        gclk_pin_i[0] <= 1'b1;
        repeat (8) @(posedge clk_i);
        check("ground clock hold", {31'h0, pool_out_o[3]}, 32'h1);
        // Inverted block clock captures on the falling pin
        bus(1, LBM_ADDR_CLKGEN, 32'h4);
        bus(1, LBM_ADDR_MC_BASE + 9'h3, 32'h302);
        repeat (4) @(posedge clk_i);
        gclk_pin_i[0] <= 1'b0;
        wait_bit("inverted block clock", 3, 1'b0);
        wait_bit("io0 follows mc3", 16, 1'b0);
        repeat (4) @(posedge clk_i);
        bus(0, LBM_ADDR_IO_STATE, 0);
        check("io state", q, 32'h00a);
        $display("test output routing done");
        // Macrocell 3 steered to 7: its own input is grounded
        bus(1, LBM_ADDR_MC_BASE + 9'h7, 32'h304);
        bus(1, LBM_ADDR_MC_BASE + 9'h3, 32'h305);
        wait_bit("steer reaches mc7", 7, 1'b1);
        check("steer grounds mc3", {31'h0, pool_out_o[3]}, 32'h0);
        // Reset term of macrocell 7 is term 38, fed by pool input 0
        bus(1, 9'h098, 32'h1);
        bus(1, LBM_ADDR_MC_BASE + 9'h7, 32'h2304);
        wait_bit("reset term mc7", 7, 1'b0);
        bus(1, LBM_ADDR_MC_BASE + 9'hb, 32'h30c);
        io_in_i[11] <= 1'b1;
        wait_bit("io input to mc11", 11, 1'b1);
        $display("test steering done");
        stop_test();
    end

    initial begin
        #40000;
        n_fail++;
        stop_test();
    end
endmodule

// ===== verilog/lbm_logic_block.sv
// One logic block: AND array, allocator chains, sixteen macrocells, I/O routing.
// Assumes routing pool inputs come from logic on clk_i; pins are asynchronous.
`timescale 1ns/1ps
module lbm_logic_block
    import lbm_pkg::*;
#(
    parameter int NUM_IN = LBM_NUM_IN
) (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Global routing pool
    input  wire logic [NUM_IN-1:0]       pool_in_i,
    output logic      [LBM_NUM_MC-1:0]   pool_out_o,
    // Pins
    input  wire logic [LBM_NUM_GCLK-1:0] gclk_pin_i,
    input  wire logic [LBM_NUM_IO-1:0]   io_in_i,
    output logic      [LBM_NUM_IO-1:0]   io_out_o,
    // Avalon-MM slave
    input  wire logic [8:0]              avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [3:0]              avs_byteenable_i,
    input  wire logic [31:0]             avs_writedata_i,
    output logic      [31:0]             avs_readdata_o,
    output logic                         avs_waitrequest_o
);

    if (NUM_IN != LBM_NUM_IN) begin : g_bad_width
        $error("lbm_logic_block: NUM_IN must be 36");
    end

    localparam logic [63:0] IN_MASK = 64'((65'd1 << NUM_IN) - 65'd1);

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================================
    // Configuration and bus slave
    logic [63:0]       pt_t [LBM_NUM_PT];
    logic [63:0]       pt_c [LBM_NUM_PT];
    lbm_mc_cfg_t       mc_cfg [LBM_NUM_MC];
    lbm_io_cfg_t       io_cfg [LBM_NUM_IO];
    lbm_clkgen_t       clkgen;
    logic              pwrup_pulse;
    logic [63:0]       next_pt_t [LBM_NUM_PT];
    logic [63:0]       next_pt_c [LBM_NUM_PT];
    lbm_mc_cfg_t       next_mc_cfg [LBM_NUM_MC];
    lbm_io_cfg_t       next_io_cfg [LBM_NUM_IO];
    lbm_clkgen_t       next_clkgen;
    logic              next_pwrup_pulse;
    lbm_bus_state_t    bus_state;
    lbm_bus_state_t    next_bus_state;
    logic              next_waitrequest;
    logic [31:0]       next_readdata;
    logic [31:0]       rd_word;
    logic [LBM_NUM_MC-1:0] mc_q;

    always_comb begin
        logic [6:0] p;
        logic [3:0] sub;
        p = avs_address_i[8:2];
        sub = avs_address_i[3:0];
        rd_word = 32'h0;
        if (avs_address_i < LBM_ADDR_PT_END) begin
            case (avs_address_i[1:0])
                2'h0:    rd_word = pt_t[p][31:0];
                2'h1:    rd_word = pt_t[p][63:32];
                2'h2:    rd_word = pt_c[p][31:0];
                default: rd_word = pt_c[p][63:32];
            endcase
        end else if (avs_address_i[8:4] == LBM_ADDR_MC_BASE[8:4]) begin
            rd_word = mc_cfg[sub];
        end else if (avs_address_i[8:4] == LBM_ADDR_IO_BASE[8:4]) begin
            if (sub < 4'(LBM_NUM_IO)) begin
                rd_word = io_cfg[sub];
            end
        end else if (avs_address_i == LBM_ADDR_CLKGEN) begin
            rd_word = clkgen;
        end else if (avs_address_i == LBM_ADDR_MC_STATE) begin
            rd_word = {16'h0, mc_q};
        end else if (avs_address_i == LBM_ADDR_IO_STATE) begin
            rd_word = {20'h0, io_out_o};
        end
    end

    // One wait cycle: request seen, then waitrequest low for one cycle
    always_comb begin
        next_bus_state   = bus_state;
        next_waitrequest = 1'b1;
        next_readdata    = 32'h0;
        case (bus_state)
            LBM_BUS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    next_bus_state   = LBM_BUS_ACK;
                    next_waitrequest = 1'b0;
                    next_readdata    = avs_read_i ? rd_word : 32'h0;
                end
            end
            LBM_BUS_ACK: begin
                next_bus_state = LBM_BUS_IDLE;
            end
            default: begin
                next_bus_state = LBM_BUS_IDLE;
            end
        endcase
    end

    // Writes land on the edge where waitrequest is sampled low
    always_comb begin
        logic       wr;
        logic [6:0] p;
        logic [3:0] sub;
        wr = (bus_state == LBM_BUS_ACK) && avs_write_i;
        p = avs_address_i[8:2];
        sub = avs_address_i[3:0];
        next_pt_t = pt_t;
        next_pt_c = pt_c;
        next_mc_cfg = mc_cfg;
        next_io_cfg = io_cfg;
        next_clkgen = clkgen;
        next_pwrup_pulse = 1'b0;
        if (wr) begin
            if (avs_address_i < LBM_ADDR_PT_END) begin
                case (avs_address_i[1:0])
                    2'h0: next_pt_t[p][31:0] =
                        be_merge(pt_t[p][31:0], avs_writedata_i, avs_byteenable_i);
                    2'h1: next_pt_t[p][63:32] = IN_MASK[63:32] &
                        be_merge(pt_t[p][63:32], avs_writedata_i, avs_byteenable_i);
                    2'h2: next_pt_c[p][31:0] =
                        be_merge(pt_c[p][31:0], avs_writedata_i, avs_byteenable_i);
                    default: next_pt_c[p][63:32] = IN_MASK[63:32] &
                        be_merge(pt_c[p][63:32], avs_writedata_i, avs_byteenable_i);
                endcase
            end else if (avs_address_i[8:4] == LBM_ADDR_MC_BASE[8:4]) begin
                next_mc_cfg[sub] = be_merge(mc_cfg[sub], avs_writedata_i, avs_byteenable_i);
                next_mc_cfg[sub].rsvd = '0;
            end else if (avs_address_i[8:4] == LBM_ADDR_IO_BASE[8:4]) begin
                if (sub < 4'(LBM_NUM_IO)) begin
                    next_io_cfg[sub] =
                        be_merge(io_cfg[sub], avs_writedata_i, avs_byteenable_i);
                    next_io_cfg[sub].rsvd = '0;
                end
            end else if (avs_address_i == LBM_ADDR_CLKGEN) begin
                next_clkgen = be_merge(clkgen, avs_writedata_i, avs_byteenable_i);
                next_clkgen.rsvd = '0;
            end else if (avs_address_i == LBM_ADDR_CTRL) begin
                next_pwrup_pulse = avs_byteenable_i[0] &&
                                   avs_writedata_i[LBM_CTRL_PWRUP_BIT];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_state         <= LBM_BUS_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0;
            pwrup_pulse       <= 1'b0;
            clkgen            <= LBM_CLKGEN_RST;
            for (int i = 0; i < LBM_NUM_PT; i++) begin
                pt_t[i] <= LBM_MASK_RST;
                pt_c[i] <= LBM_MASK_RST;
            end
            for (int i = 0; i < LBM_NUM_MC; i++) begin
                mc_cfg[i] <= LBM_MC_CFG_RST;
            end
            for (int i = 0; i < LBM_NUM_IO; i++) begin
                io_cfg[i] <= LBM_IO_CFG_RST;
            end
        end else begin
            bus_state         <= next_bus_state;
            avs_waitrequest_o <= next_waitrequest;
            avs_readdata_o    <= next_readdata;
            pwrup_pulse       <= next_pwrup_pulse;
            clkgen            <= next_clkgen;
            pt_t              <= next_pt_t;
            pt_c              <= next_pt_c;
            mc_cfg            <= next_mc_cfg;
            io_cfg            <= next_io_cfg;
        end
    end

    // ==========================================================================
    // Pin synchronisers
    logic [LBM_NUM_GCLK-1:0] gclk_s1;
    logic [LBM_NUM_GCLK-1:0] gclk_s2;
    logic [LBM_NUM_IO-1:0]   io_s1;
    logic [LBM_NUM_IO-1:0]   io_s2;
    logic [LBM_NUM_IO-1:0]   io_s3;

    always_ff @(posedge clk_i) begin
        gclk_s1 <= gclk_pin_i;
        gclk_s2 <= gclk_s1;
        io_s1   <= io_in_i;
        io_s2   <= io_s1;
        io_s3   <= io_s2;
    end

    // ==========================================================================
    // AND array and block clock generator
    logic [LBM_NUM_PT-1:0] pt;
    logic [3:0]            bclk;
    logic [63:0]           in_ext;

    // Only pool inputs reach the array; no macrocell feeds it locally
    assign in_ext = 64'(pool_in_i);

    for (genvar p = 0; p < LBM_NUM_PT; p++) begin : g_pt
        // Unused terms (no input selected) stay low rather than high
        assign pt[p] = (|(pt_t[p] | pt_c[p])) &
                       (&(in_ext | ~pt_t[p])) & (&(~in_ext | ~pt_c[p]));
    end

    for (genvar b = 0; b < 4; b++) begin : g_bclk
        assign bclk[b] = gclk_s2[clkgen.bclk[b].pin] ^ clkgen.bclk[b].inv;
    end

    // ==========================================================================
    // Allocator and expansion chains
    logic [LBM_NUM_MC-1:0] cl_sum;
    logic [LBM_NUM_MC-1:0] fast;
    logic [LBM_NUM_MC-1:0] carry;
    logic [LBM_NUM_MC-1:0] incoming;
    logic [LBM_NUM_MC-1:0] alloc;

    for (genvar n = 0; n < LBM_NUM_MC; n++) begin : g_alloc
        logic [4:0] cl;
        logic [4:0] divert;
        assign cl = pt[n*LBM_PT_PER_MC +: LBM_PT_PER_MC];
        assign divert[0] = (mc_cfg[n].clk_sel == LBM_CLK_PT) ||
                           (mc_cfg[n].clk_sel == LBM_CLK_PT_INV);
        assign divert[1] = (mc_cfg[n].ce_sel == LBM_CE_INIT) ||
                           (mc_cfg[n].ce_sel == LBM_CE_INIT_INV);
        assign divert[2] = mc_cfg[n].setrst_en;
        assign divert[3] = mc_cfg[n].setrst_en;
        assign divert[4] = 1'b0;
        assign cl_sum[n] = |(cl & ~divert);
        assign fast[n]   = |cl;
        // Wrap hop carries only the last cluster, so a full ring cannot loop
        if (n >= LBM_CHAIN_STEP) begin : g_mid
            assign incoming[n] = mc_cfg[n-LBM_CHAIN_STEP].steer &
                                 carry[n-LBM_CHAIN_STEP];
        end else begin : g_wrap
            assign incoming[n] = mc_cfg[n+12].steer & cl_sum[n+12];
        end
        assign carry[n] = cl_sum[n] | incoming[n];
        assign alloc[n] = mc_cfg[n].steer ? 1'b0 : carry[n];
    end

    // ==========================================================================
    // Macrocells
    logic [LBM_NUM_MC-1:0] clk_prev;
    logic [LBM_NUM_MC-1:0] next_mc_q;
    logic [LBM_NUM_MC-1:0] sel_clk;
    logic                  load_pwrup;

    assign load_pwrup = rst_i || pwrup_pulse;

    for (genvar n = 0; n < LBM_NUM_MC; n++) begin : g_mc
        lbm_mc_cfg_t c;
        logic        d;
        logic        ce;
        logic        pu_val;
        assign c = mc_cfg[n];
        assign d = c.use_io ? (c.io_delay ? io_s3[n % LBM_NUM_IO]
                                          : io_s2[n % LBM_NUM_IO])
                            : (alloc[n] ^ c.xor_inv);

        always_comb begin
            case (c.clk_sel)
                LBM_CLK_BLOCK0: sel_clk[n] = bclk[0];
                LBM_CLK_BLOCK1: sel_clk[n] = bclk[1];
                LBM_CLK_BLOCK2: sel_clk[n] = bclk[2];
                LBM_CLK_BLOCK3: sel_clk[n] = bclk[3];
                LBM_CLK_PT:     sel_clk[n] = pt[n*LBM_PT_PER_MC];
                LBM_CLK_PT_INV: sel_clk[n] = ~pt[n*LBM_PT_PER_MC];
                LBM_CLK_SHARED: sel_clk[n] = pt[LBM_SHARED_PT];
                default:        sel_clk[n] = 1'b0;
            endcase
            case (c.ce_sel)
                LBM_CE_INIT:     ce = pt[n*LBM_PT_PER_MC+1];
                LBM_CE_INIT_INV: ce = ~pt[n*LBM_PT_PER_MC+1];
                LBM_CE_SHARED:   ce = pt[LBM_SHARED_PT];
                default:         ce = 1'b1;
            endcase
        end

        // Swap flips the preset/reset sense, power-up value included
        assign pu_val = (c.init_en & c.init_set) ^ c.swap;

        always_comb begin
            next_mc_q[n] = mc_q[n];
            if (load_pwrup) begin
                next_mc_q[n] = pu_val;
            end else if (c.init_en && pt[LBM_INIT_PT]) begin
                next_mc_q[n] = c.init_set ^ c.swap;
            end else if (c.setrst_en && pt[n*LBM_PT_PER_MC+3]) begin
                next_mc_q[n] = c.swap;
            end else if (c.setrst_en && pt[n*LBM_PT_PER_MC+2]) begin
                next_mc_q[n] = ~c.swap;
            end else if (c.latch_mode) begin
                if (sel_clk[n] && ce) begin
                    next_mc_q[n] = d;
                end
            end else if (sel_clk[n] && !clk_prev[n] && ce) begin
                next_mc_q[n] = d;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        mc_q     <= next_mc_q;
        // Tracks the clock through reset too, so release shows no false edge
        clk_prev <= sel_clk;
    end

    assign pool_out_o = mc_q;

    // ==========================================================================
    // Output routing pool and fast-path selector
    logic [LBM_NUM_IO-1:0] next_io_out;

    for (genvar k = 0; k < LBM_NUM_IO; k++) begin : g_io
        logic [3:0] base;
        logic [3:0] pick;
        assign base = LBM_ORP_FIRST[k];
        assign pick = base + {1'b0, io_cfg[k].orp_sel};
        always_comb begin
            case (io_cfg[k].out_sel)
                LBM_OUT_ORP:    next_io_out[k] = mc_q[pick];
                LBM_OUT_FAST:   next_io_out[k] = fast[base];
                LBM_OUT_FAST_N: next_io_out[k] = ~fast[base];
                default:        next_io_out[k] = mc_q[base];
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_out_o <= '0;
        end else begin
            io_out_o <= next_io_out;
        end
    end

endmodule

// ===== verilog/lbm_pkg.sv
// Constants, field layouts and carrier types for the logic block model.
// Assumes one 50 MHz clock domain and an Avalon-MM master with word addressing.
// Operation
// - The block takes exactly 36 inputs from the routing pool and returns all outputs.
// - Feedback to the same block still goes through the routing pool, never locally.
// - Block outputs also go to the output routing pool feeding the I/O cells.
// - Sixteen macrocells, each fed by one allocator output.
// - Four stride-four wrapping chains, limits 75, 80, 75 and 70 terms.
// - A steered super cluster leaves every other destination at zero.
// - Each macrocell has a programmable XOR, then a register or latch.
// - Storage may take I/O cell input directly, with optional added delay.
// - Clock is picked 8:1 from four block clocks, term clocks, shared clock, ground.
// - Clock enable is picked 4:1 from init term, inverse, shared clock, high.
// - One block-level initialization term reaches every macrocell.
// - Two cluster terms may be diverted as the macrocell's set and reset.
// - A swap option exchanges reset and preset, power-up state included.
// - Power-up: set-on-init cells come up set, all others cleared; swap inverts either value.
// - Four global clock pins feed the pool and a per-block clock generator.
// - Each of twelve I/O cells selects among eight consecutive wrapping macrocells.
// - A 4:1 selector routes fast path, its inverse, or register straight out.
package lbm_pkg;

    // ==========================================================================
    // Sizes
    localparam int LBM_NUM_IN      = 36;
    localparam int LBM_NUM_MC      = 16;
    localparam int LBM_NUM_IO      = 12;
    localparam int LBM_NUM_GCLK    = 4;
    localparam int LBM_PT_PER_MC   = 5;
    localparam int LBM_NUM_PT      = 82;
    localparam int LBM_SHARED_PT   = 80;
    localparam int LBM_INIT_PT     = 81;
    localparam int LBM_CHAIN_STEP  = 4;
    localparam int LBM_CHAIN_MAX_0 = 75;
    localparam int LBM_CHAIN_MAX_1 = 80;
    localparam int LBM_CHAIN_MAX_2 = 75;
    localparam int LBM_CHAIN_MAX_3 = 70;

    // First macrocell offered to each I/O cell
    localparam logic [3:0] LBM_ORP_FIRST [LBM_NUM_IO] = '{
        4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'he};

    // ==========================================================================
    // Word addresses
    localparam logic [8:0] LBM_ADDR_PT_END    = 9'h148;
    localparam logic [8:0] LBM_ADDR_MC_BASE   = 9'h150;
    localparam logic [8:0] LBM_ADDR_IO_BASE   = 9'h160;
    localparam logic [8:0] LBM_ADDR_CLKGEN    = 9'h170;
    localparam logic [8:0] LBM_ADDR_CTRL      = 9'h171;
    localparam logic [8:0] LBM_ADDR_MC_STATE  = 9'h172;
    localparam logic [8:0] LBM_ADDR_IO_STATE  = 9'h173;
    localparam int         LBM_CTRL_PWRUP_BIT = 0;

    // ==========================================================================
    // Selector codes
    localparam logic [2:0] LBM_CLK_BLOCK0  = 3'h0;
    localparam logic [2:0] LBM_CLK_BLOCK1  = 3'h1;
    localparam logic [2:0] LBM_CLK_BLOCK2  = 3'h2;
    localparam logic [2:0] LBM_CLK_BLOCK3  = 3'h3;
    localparam logic [2:0] LBM_CLK_PT      = 3'h4;
    localparam logic [2:0] LBM_CLK_PT_INV  = 3'h5;
    localparam logic [2:0] LBM_CLK_SHARED  = 3'h6;
    localparam logic [2:0] LBM_CLK_GROUND  = 3'h7;
    localparam logic [1:0] LBM_CE_INIT     = 2'h0;
    localparam logic [1:0] LBM_CE_INIT_INV = 2'h1;
    localparam logic [1:0] LBM_CE_SHARED   = 2'h2;
    localparam logic [1:0] LBM_CE_HIGH     = 2'h3;
    localparam logic [1:0] LBM_OUT_ORP     = 2'h0;
    localparam logic [1:0] LBM_OUT_FAST    = 2'h1;
    localparam logic [1:0] LBM_OUT_FAST_N  = 2'h2;
    localparam logic [1:0] LBM_OUT_REG     = 2'h3;

    // ==========================================================================
    // Carriers
    typedef struct packed {
        logic [17:0] rsvd;
        logic        setrst_en;
        logic        swap;
        logic        init_set;
        logic        init_en;
        logic [1:0]  ce_sel;
        logic [2:0]  clk_sel;
        logic        io_delay;
        logic        use_io;
        logic        latch_mode;
        logic        xor_inv;
        logic        steer;
    } lbm_mc_cfg_t;

    typedef struct packed {
        logic [26:0] rsvd;
        logic [1:0]  out_sel;
        logic [2:0]  orp_sel;
    } lbm_io_cfg_t;

    typedef struct packed {
        logic       inv;
        logic [1:0] pin;
    } lbm_bclk_t;

    typedef struct packed {
        logic [19:0]     rsvd;
        lbm_bclk_t [3:0] bclk;
    } lbm_clkgen_t;

    typedef enum logic [1:0] {
        LBM_BUS_IDLE = 2'b01,
        LBM_BUS_ACK  = 2'b10
    } lbm_bus_state_t;

    localparam lbm_mc_cfg_t LBM_MC_CFG_RST  = 32'h0;
    localparam lbm_io_cfg_t LBM_IO_CFG_RST  = 32'h0;
    localparam lbm_clkgen_t LBM_CLKGEN_RST  = 32'h0;
    localparam logic [63:0] LBM_MASK_RST    = 64'h0;

endpackage
